// *** hw/smlc_mode_ctrl.sv ***
/*
   Mode and loopback control for two packet interface cores, with an Avalon-MM
   register slave. Assumes link clocks and link pins are asynchronous to clock,
   and that internal datapath signals share clock.
*/
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "smlc_params.svh"
// Contract
// - Static select 0 resets dynamic alignment
// - Any data width works in either capture
// - Manual skew applies the three delay taps
// - Auto skew ignores taps, centers clock
// - Quarter-rate bit bypasses the core's own TX PLL
// - Quarter-rate also resets dynamic alignment
// - Static select bypasses alignment, keeps TX PLL
// - Near serial loop: TX serial to RX
// - Far loop: deserializer output to serializer
// - Near parallel loop uses test clock
// - Bit three selects status I/O standard
// - Parity forcing leaves far loop untouched
// - Parity force bits invert parity outputs
module smlc_mode_ctrl #(
   parameter int LW = 16,
   parameter int DW = 128,
   parameter int AW = 20
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Avalon-MM register slave.
   input wire logic [AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Fabric controls.
   input wire logic [1:0] fabric_core_reset,
   input wire logic manual_skew_mode_a,
   input wire logic manual_skew_mode_b,
   input wire logic [2:0] clock_delay_taps_a,
   input wire logic [2:0] clock_delay_taps_b,
   input wire logic [1:0][1:0] agg_width_sel,
   // Asynchronous link and clock inputs.
   input wire logic [1:0] rx_line_clock,
   input wire logic [1:0][LW-1:0] rx_line_data,
   input wire logic [1:0][1:0] tx_status_in,
   input wire logic [1:0] tx_status_clock,
   input wire logic [1:0] tx_pll_clock,
   input wire logic [1:0] fabric_tx_ref_clock,
   input wire logic loop_test_clock,
   // Internal datapath sources.
   input wire logic [1:0][LW-1:0] tx_serial_out,
   input wire logic [1:0][DW-1:0] rx_deserializer_out,
   input wire logic [1:0][DW-1:0] tx_data_path_out,
   input wire logic [1:0][1:0] rx_status_path_out,
   input wire logic [1:0][3:0] tx_parity,
   input wire logic [1:0][1:0] rx_status_parity,
   // Mode outputs.
   output logic [1:0] dyn_align_reset,
   output logic [1:0] align_bypass,
   output logic [1:0] static_capture_en,
   output logic [1:0] pll_bypass,
   output logic [1:0] auto_center_en,
   output logic [1:0][2:0] rx_clock_delay_taps,
   output logic [1:0] status_io_standard_sel,
   output logic [1:0][1:0] agg_width,
   // Steered datapath outputs.
   output logic [1:0][LW-1:0] rx_serial_in,
   output logic [1:0][DW-1:0] serializer_in,
   output logic [1:0][DW-1:0] rx_data_path_in,
   output logic [1:0][1:0] tx_status_path_in,
   output logic [1:0][1:0] rx_status_out,
   output logic [1:0][3:0] tx_parity_out,
   output logic [1:0][1:0] rx_status_parity_out,
   // Steered clock levels.
   output logic [1:0] tx_data_clock_out,
   output logic [1:0] rx_status_clock_out,
   output logic [1:0] hs_block_clock_out
);
   import smlc_pkg::*;

   if (LW < 1 || DW < 1 || AW < 20) begin : g_bad_params
      $error("smlc_mode_ctrl: LW and DW must be positive and AW at least 20");
   end

   // True when the bus address selects the register with this index.
   function automatic logic reg_hit(input logic [AW-1:0] addr, input logic [17:0] idx);
      reg_hit = (addr == AW'({idx, 2'b00}));
   endfunction : reg_hit

   logic waitrequest_r;
   logic [31:0] readdata_r;
   logic [31:0] rd_nxt;
   logic [1:0][7:0] cfg_r;
   logic [1:0][7:0] act_cfg_r;
   logic [1:0][31:0] sts;
   logic [1:0] manual_skew;
   logic [1:0][2:0] taps_in;

   // Two-stage synchronisers for everything from outside the clock domain.
   logic [1:0] rxclk_s1_r, rxclk_s2_r;
   logic [1:0][LW-1:0] rxdat_s1_r, rxdat_s2_r;
   logic [1:0][1:0] tstat_s1_r, tstat_s2_r;
   logic [1:0] tsclk_s1_r, tsclk_s2_r;
   logic [1:0] txpll_s1_r, txpll_s2_r;
   logic [1:0] tref_s1_r, tref_s2_r;
   logic [1:0] crst_s1_r, crst_s2_r;
   logic test_s1_r, test_s2_r;
   logic [1:0] tref_prev_r;
   logic [1:0] ref_div_r;
   logic [`SMLC_STAT_DIV_W-1:0] stat_div_r;

   assign manual_skew = {manual_skew_mode_b, manual_skew_mode_a};
   assign taps_in = {clock_delay_taps_b, clock_delay_taps_a};
   assign avs_waitrequest = waitrequest_r;
   assign avs_readdata = readdata_r;

   // Synchroniser chains; only the second stage is read by logic.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rxclk_s1_r <= '0;
         rxclk_s2_r <= '0;
         rxdat_s1_r <= '0;
         rxdat_s2_r <= '0;
         tstat_s1_r <= '0;
         tstat_s2_r <= '0;
         tsclk_s1_r <= '0;
         tsclk_s2_r <= '0;
         txpll_s1_r <= '0;
         txpll_s2_r <= '0;
         tref_s1_r <= '0;
         tref_s2_r <= '0;
         crst_s1_r <= '0;
         crst_s2_r <= '0;
         test_s1_r <= 1'b0;
         test_s2_r <= 1'b0;
      end else begin
         rxclk_s1_r <= rx_line_clock;
         rxclk_s2_r <= rxclk_s1_r;
         rxdat_s1_r <= rx_line_data;
         rxdat_s2_r <= rxdat_s1_r;
         tstat_s1_r <= tx_status_in;
         tstat_s2_r <= tstat_s1_r;
         tsclk_s1_r <= tx_status_clock;
         tsclk_s2_r <= tsclk_s1_r;
         txpll_s1_r <= tx_pll_clock;
         txpll_s2_r <= txpll_s1_r;
         tref_s1_r <= fabric_tx_ref_clock;
         tref_s2_r <= tref_s1_r;
         crst_s1_r <= fabric_core_reset;
         crst_s2_r <= crst_s1_r;
         test_s1_r <= loop_test_clock;
         test_s2_r <= test_s1_r;
      end
   end

   // The fabric reference runs at twice the line rate in quarter-rate mode, so halving
   // it on each rising edge gives a transmit clock at the line rate.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tref_prev_r <= '0;
         ref_div_r <= '0;
      end else begin
         tref_prev_r <= tref_s2_r;
         ref_div_r <= ref_div_r ^ (tref_s2_r & ~tref_prev_r);
      end
   end

   // Status clock runs at quarter rate except in far loop, which passes the link status clock; full-rate status is not offered.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         stat_div_r <= '0;
      end else begin
         stat_div_r <= stat_div_r + `SMLC_STAT_DIV_W'(1);
      end
   end

   // Bus handshake: waitrequest drops one cycle after a request appears, the access
   // completes on that edge, then waitrequest rises again so each access costs two cycles.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         waitrequest_r <= 1'b1;
         readdata_r <= `SMLC_RD_ZERO;
      end else if (waitrequest_r) begin
         if (avs_read || avs_write) begin
            waitrequest_r <= 1'b0;
            readdata_r <= avs_read ? rd_nxt : `SMLC_RD_ZERO;
         end
      end else begin
         waitrequest_r <= 1'b1;
      end
   end

   // Software copy of each control byte, written on the completing edge only.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cfg_r <= {`SMLC_CFG_RESET, `SMLC_CFG_RESET};
      end else if (!waitrequest_r && avs_write) begin
         if (reg_hit(avs_address, `SMLC_IDX_CFG_A)) begin
            cfg_r[0] <= avs_writedata[7:0];
         end
         if (reg_hit(avs_address, `SMLC_IDX_CFG_B)) begin
            cfg_r[1] <= avs_writedata[7:0];
         end
      end
   end

   // A new setting takes hold only while that core's fabric reset is asserted, so
   // modes never change under live traffic.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         act_cfg_r <= {`SMLC_CFG_RESET, `SMLC_CFG_RESET};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (crst_s2_r[c]) begin
               act_cfg_r[c] <= cfg_r[c];
            end
         end
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      if (reg_hit(avs_address, `SMLC_IDX_CFG_A)) begin
         rd_nxt = {24'h00_0000, cfg_r[0]};
      end else if (reg_hit(avs_address, `SMLC_IDX_CFG_B)) begin
         rd_nxt = {24'h00_0000, cfg_r[1]};
      end else if (reg_hit(avs_address, `SMLC_IDX_STS_A)) begin
         rd_nxt = sts[0];
      end else if (reg_hit(avs_address, `SMLC_IDX_STS_B)) begin
         rd_nxt = sts[1];
      end else begin
         rd_nxt = `SMLC_RD_ZERO;
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_core
      smlc_mode_if mif ();

      assign mif.cfg = act_cfg_r[c];
      assign mif.manual_skew = manual_skew[c];
      assign mif.taps = taps_in[c];

      smlc_core_decode u_decode (
         .mif(mif.dec)
      );

      // Status word: active byte above, live decode below.
      assign sts[c] = (32'(act_cfg_r[c]) << `SMLC_STS_ACT_LSB) |
         32'({rxclk_s2_r[c], mif.loop, mif.pll_bypass, mif.static_cap, mif.dyn_align_rst});

      // Capture and skew controls; width selection is independent of capture mode.
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            dyn_align_reset[c] <= 1'b1;
            align_bypass[c] <= 1'b0;
            static_capture_en[c] <= 1'b1;
            pll_bypass[c] <= 1'b0;
            auto_center_en[c] <= 1'b1;
            rx_clock_delay_taps[c] <= 3'h0;
            status_io_standard_sel[c] <= 1'b0;
            agg_width[c] <= 2'h0;
         end else begin
            dyn_align_reset[c] <= mif.dyn_align_rst;
            align_bypass[c] <= mif.align_bypass;
            static_capture_en[c] <= mif.static_cap;
            pll_bypass[c] <= mif.pll_bypass;
            auto_center_en[c] <= mif.auto_center;
            rx_clock_delay_taps[c] <= mif.eff_taps;
            status_io_standard_sel[c] <= mif.status_diff;
            agg_width[c] <= agg_width_sel[c];
         end
      end

      // Data and status steering for the three loop paths.
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            rx_serial_in[c] <= '0;
            serializer_in[c] <= '0;
            rx_data_path_in[c] <= '0;
            tx_status_path_in[c] <= '0;
            rx_status_out[c] <= '0;
         end else begin
            rx_serial_in[c] <= (mif.loop == SMLC_LOOP_NEAR_SERIAL) ? tx_serial_out[c] : rxdat_s2_r[c];
            serializer_in[c] <= (mif.loop == SMLC_LOOP_FAR) ? rx_deserializer_out[c]
               : tx_data_path_out[c];
            rx_data_path_in[c] <= (mif.loop == SMLC_LOOP_NEAR_PARALLEL) ? tx_data_path_out[c]
               : rx_deserializer_out[c];
            tx_status_path_in[c] <= (mif.loop == SMLC_LOOP_NEAR_SERIAL || mif.loop == SMLC_LOOP_NEAR_PARALLEL)
               ? rx_status_path_out[c] : tstat_s2_r[c];
            rx_status_out[c] <= (mif.loop == SMLC_LOOP_FAR) ? tstat_s2_r[c] : rx_status_path_out[c];
         end
      end

      // Parity forcing; the decoder keeps it off during far loop.
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            tx_parity_out[c] <= 4'h0;
            rx_status_parity_out[c] <= 2'h0;
         end else begin
            tx_parity_out[c] <= tx_parity[c] ^ {4{mif.tx_par_inv}};
            rx_status_parity_out[c] <= rx_status_parity[c] ^ {2{mif.rx_par_inv}};
         end
      end

      // Clock steering. These are sampled levels, so they carry a three-cycle latency (four through the reference divider) and
      // cannot follow clocks faster than a quarter of clock.
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            tx_data_clock_out[c] <= 1'b0;
            rx_status_clock_out[c] <= 1'b0;
            hs_block_clock_out[c] <= 1'b0;
         end else begin
            if (mif.loop == SMLC_LOOP_FAR) begin
               tx_data_clock_out[c] <= rxclk_s2_r[c];
            end else if (mif.pll_bypass) begin
               tx_data_clock_out[c] <= ref_div_r[c];
            end else begin
               tx_data_clock_out[c] <= txpll_s2_r[c];
            end
            rx_status_clock_out[c] <= (mif.loop == SMLC_LOOP_FAR) ? tsclk_s2_r[c]
               : stat_div_r[`SMLC_STAT_DIV_W-1];
            hs_block_clock_out[c] <= (mif.loop == SMLC_LOOP_NEAR_PARALLEL) ? test_s2_r
               : txpll_s2_r[c];
         end
      end
   end
endmodule : smlc_mode_ctrl
`default_nettype wire

// *** hw/smlc_params.svh ***
/*
   Constants for the packet interface mode and loopback control block.
   Assumes it is included by its bare name from the top module, the decoder and the bench.
*/
`ifndef SMLC_PARAMS_SVH
`define SMLC_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SMLC_IDX_CFG_A 18'h3_0915
`define SMLC_IDX_CFG_B 18'h3_0A15
`define SMLC_IDX_STS_A 18'h3_0916
`define SMLC_IDX_STS_B 18'h3_0A16

// Control register reset value and field positions.
`define SMLC_CFG_RESET 8'h00
`define SMLC_BIT_QUARTER 0
`define SMLC_BIT_FAR 1
`define SMLC_BIT_STATIC 2
`define SMLC_BIT_STATUS_IO 3
`define SMLC_BIT_NEAR_SER 4
`define SMLC_BIT_NEAR_PAR 5
`define SMLC_BIT_TX_PAR 6
`define SMLC_BIT_RX_PAR 7

// Status register: active control copy sits at this bit position.
`define SMLC_STS_ACT_LSB 8

// Bus answer value for unmapped reads and unused upper bits.
`define SMLC_RD_ZERO 32'h0000_0000

// Quarter-rate status clock divider width (clock divided by four).
`define SMLC_STAT_DIV_W 2

`endif

// *** hw/smlc_pkg.sv ***
/*
   Types shared by the mode and loopback control modules.
   Assumes nothing beyond the constants header.
*/
package smlc_pkg;
   // Which loopback path is in force for one core.
   typedef enum logic [1:0] {
      SMLC_LOOP_NONE,
      SMLC_LOOP_NEAR_SERIAL,
      SMLC_LOOP_FAR,
      SMLC_LOOP_NEAR_PARALLEL
   } smlc_loop_t;
endpackage : smlc_pkg

// *** hw/smlc_mode_if.sv ***
/*
   Carrier between the top module and one core's mode decoder.
   Assumes the top drives the active settings and reads back the decode.
*/
`timescale 1ns/10ps
`default_nettype none
interface smlc_mode_if;
   logic [7:0] cfg;
   logic manual_skew;
   logic [2:0] taps;
   logic dyn_align_rst;
   logic align_bypass;
   logic static_cap;
   logic pll_bypass;
   logic auto_center;
   logic [2:0] eff_taps;
   logic status_diff;
   logic tx_par_inv;
   logic rx_par_inv;
   smlc_pkg::smlc_loop_t loop;
   modport host (output cfg, manual_skew, taps,
      input dyn_align_rst, align_bypass, static_cap, pll_bypass, auto_center, eff_taps,
      status_diff, tx_par_inv, rx_par_inv, loop);
   modport dec (input cfg, manual_skew, taps,
      output dyn_align_rst, align_bypass, static_cap, pll_bypass, auto_center, eff_taps,
      status_diff, tx_par_inv, rx_par_inv, loop);
endinterface : smlc_mode_if
`default_nettype wire

// *** hw/smlc_core_decode.sv ***
/*
   Combinational decode of one core's active control byte and fabric skew inputs.
   Assumes the caller registers every result before it leaves the block.
*/
`timescale 1ns/10ps
`default_nettype none
`include "smlc_params.svh"
module smlc_core_decode (
   // Settings in, decode out.
   smlc_mode_if.dec mif
);
   import smlc_pkg::*;

   // Capture mode; quarter rate overrides the static select bit.
   always_comb begin
      mif.dyn_align_rst = mif.cfg[`SMLC_BIT_QUARTER] | ~mif.cfg[`SMLC_BIT_STATIC];
      mif.align_bypass = mif.cfg[`SMLC_BIT_STATIC] | mif.cfg[`SMLC_BIT_QUARTER];
      mif.static_cap = mif.dyn_align_rst | mif.align_bypass;
      mif.pll_bypass = mif.cfg[`SMLC_BIT_QUARTER];
      mif.status_diff = mif.cfg[`SMLC_BIT_STATUS_IO];
   end

   // Manual skew takes the taps; otherwise taps are ignored and centering is automatic.
   always_comb begin
      mif.auto_center = ~mif.manual_skew;
      mif.eff_taps = mif.manual_skew ? mif.taps : 3'h0;
   end

   // Far end wins over any near-end bits; the parallel loop needs both near bits.
   always_comb begin
      if (mif.cfg[`SMLC_BIT_FAR]) begin
         mif.loop = SMLC_LOOP_FAR;
      end else if (mif.cfg[`SMLC_BIT_NEAR_PAR] && mif.cfg[`SMLC_BIT_NEAR_SER]) begin
         mif.loop = SMLC_LOOP_NEAR_PARALLEL;
      end else if (mif.cfg[`SMLC_BIT_NEAR_SER]) begin
         mif.loop = SMLC_LOOP_NEAR_SERIAL;
      end else begin
         mif.loop = SMLC_LOOP_NONE;
      end
   end

   // Forced parity errors stay off while the far-end path is looped.
   always_comb begin
      mif.tx_par_inv = mif.cfg[`SMLC_BIT_TX_PAR] & ~mif.cfg[`SMLC_BIT_FAR];
      mif.rx_par_inv = mif.cfg[`SMLC_BIT_RX_PAR] & ~mif.cfg[`SMLC_BIT_FAR];
   end
endmodule : smlc_core_decode
`default_nettype wire

// *** tb/smlc_mode_ctrl_properties.sv ***
/*
   Checker for the mode and loopback control block.
   Assumes it is bound to smlc_mode_ctrl and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module smlc_mode_ctrl_props (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Bus handshake.
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // Fabric controls.
   input wire logic manual_skew_mode_a,
   input wire logic [2:0] clock_delay_taps_a,
   input wire logic [1:0][1:0] agg_width_sel,
   // Mode outputs.
   input wire logic [1:0] dyn_align_reset,
   input wire logic [1:0] align_bypass,
   input wire logic [1:0] static_capture_en,
   input wire logic [1:0] pll_bypass,
   input wire logic [1:0] auto_center_en,
   input wire logic [1:0][2:0] rx_clock_delay_taps,
   input wire logic [1:0][1:0] agg_width
);
   // One domain, so clock and reset are given once for every property.
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // Receive capture is never left free running: it is reset or bypassed.
   property p_cap_mode; static_capture_en == 2'b11 && (dyn_align_reset | align_bypass) == 2'b11; endproperty
   property p_quarter_a; pll_bypass[0] |-> dyn_align_reset[0] && align_bypass[0]; endproperty
   property p_quarter_b; pll_bypass[1] |-> dyn_align_reset[1] && align_bypass[1]; endproperty
   property p_taps; manual_skew_mode_a |=> rx_clock_delay_taps[0] == $past(clock_delay_taps_a) && !auto_center_en[0];
   endproperty
   property p_auto; !manual_skew_mode_a |=> rx_clock_delay_taps[0] == 3'h0 && auto_center_en[0]; endproperty
   property p_width; 1'b1 |=> agg_width == $past(agg_width_sel); endproperty
   // The slave answers each request one cycle after it sees it, for one cycle only.
   property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_wait_idle; !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest; endproperty
   a_cap_mode: assert property (p_cap_mode) else $error("capture mode flags inconsistent");
   a_quarter_a: assert property (p_quarter_a) else $error("quarter rate left alignment running");
   a_quarter_b: assert property (p_quarter_b) else $error("quarter rate left alignment on core b");
   a_taps: assert property (p_taps) else $error("taps not applied under manual skew");
   a_auto: assert property (p_auto) else $error("taps not ignored under auto skew");
   a_width: assert property (p_width) else $error("aggregation width not passed");
   a_wait_ans: assert property (p_wait_ans) else $error("request not answered in one cycle");
   a_wait_one: assert property (p_wait_one) else $error("answer held longer than one cycle");
   a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
   // Main scenarios reached.
   c_quarter: cover property (pll_bypass[0]);
   c_taps: cover property (manual_skew_mode_a && clock_delay_taps_a == 3'h7);
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule : smlc_mode_ctrl_props
bind smlc_mode_ctrl smlc_mode_ctrl_props u_props (.clock, .reset, .avs_read, .avs_write, .avs_waitrequest,
   .manual_skew_mode_a, .clock_delay_taps_a, .agg_width_sel, .dyn_align_reset, .align_bypass,
   .static_capture_en, .pll_bypass, .auto_center_en, .rx_clock_delay_taps, .agg_width);
`default_nettype wire

// *** tb/smlc_link_partner.sv ***
/*
   Behavioural far-end link device for both cores.
   Assumes its pins are sampled asynchronously by the block.
*/
`timescale 1ns/10ps
`default_nettype none
module smlc_link_partner #(
   parameter int LW = 16
) (
   // Link pins toward the block.
   output logic [1:0] rx_line_clock,
   output logic [1:0][LW-1:0] rx_line_data,
   output logic [1:0][1:0] tx_status_in,
   output logic [1:0] tx_status_clock
);
   // The line clock runs free, so data, clock and control are present before setup.
   initial begin
      rx_line_clock = 2'b00;
      tx_status_clock = 2'b00;
      rx_line_data = '0;
      tx_status_in = 4'h5;
   end
   always #80 rx_line_clock = ~rx_line_clock;
   always #120 tx_status_clock = ~tx_status_clock;
   // Data changes on both line edges, so a stale capture shows at once.
   always @(rx_line_clock[0]) rx_line_data <= {~rx_line_data[1], rx_line_data[0] + 1'b1};
   // Status words rotate on the status clock.
   always @(posedge tx_status_clock[0]) tx_status_in <= {tx_status_in[0], ~tx_status_in[1]};
endmodule : smlc_link_partner
`default_nettype wire

// *** tb/tb_smlc_mode_ctrl.sv ***
/*
   Self-checking bench for the mode and loopback control block.
   Assumes the link partner model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "smlc_params.svh"
module tb_smlc_mode_ctrl;
   localparam int LW = 8;
   localparam int DW = 32;
   localparam logic [7:0] CFGS [14] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h07, 8'h06, 8'h02, 8'h10, 8'h30, 8'h20,
      8'h32, 8'h12, 8'hC2, 8'hC8};
   logic [19:0] cadr [2] = '{{`SMLC_IDX_CFG_A, 2'b00}, {`SMLC_IDX_CFG_B, 2'b00}};
   logic [19:0] sadr [2] = '{{`SMLC_IDX_STS_A, 2'b00}, {`SMLC_IDX_STS_B, 2'b00}};
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [19:0] avs_address = 20'h0_0000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [1:0] fabric_core_reset = 2'b00;
   logic manual_skew_mode_a = 1'b0;
   logic manual_skew_mode_b = 1'b0;
   logic [2:0] clock_delay_taps_a = 3'h0;
   logic [2:0] clock_delay_taps_b = 3'h0;
   logic [1:0][1:0] agg_width_sel = 4'h0;
   logic [1:0] tx_pll_clock = 2'b00;
   logic [1:0] fabric_tx_ref_clock = 2'b00;
   logic loop_test_clock = 1'b0;
   logic [1:0][LW-1:0] tx_serial_out = '0;
   logic [1:0][DW-1:0] rx_deserializer_out = '0;
   logic [1:0][DW-1:0] tx_data_path_out = '0;
   logic [1:0][1:0] rx_status_path_out = 4'h0;
   logic [1:0][3:0] tx_parity = 8'h00;
   logic [1:0][1:0] rx_status_parity = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] rx_line_clock, tx_status_clock, dyn_align_reset, align_bypass, pll_bypass, auto_center_en;
   logic [1:0] status_io_standard_sel;
   logic [1:0][LW-1:0] rx_line_data, rx_serial_in;
   logic [1:0][1:0] tx_status_in, agg_width, tx_status_path_in, rx_status_out, rx_status_parity_out;
   logic [1:0][2:0] rx_clock_delay_taps;
   logic [1:0][DW-1:0] serializer_in, rx_data_path_in;
   logic [1:0][3:0] tx_parity_out;
   int num_errors = 0;
   int n_checks = 0;
   // Clocks; the quarter-rate reference runs at twice the line rate.
   always #10 clock = ~clock;
   always #25 tx_pll_clock = ~tx_pll_clock;
   always #40 fabric_tx_ref_clock = ~fabric_tx_ref_clock;
   always #60 loop_test_clock = ~loop_test_clock;
   smlc_link_partner #(.LW(LW)) u_link (.rx_line_clock, .rx_line_data, .tx_status_in, .tx_status_clock);
   smlc_mode_ctrl #(.LW(LW), .DW(DW), .AW(20)) uut (.clock, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .fabric_core_reset, .manual_skew_mode_a,
      .manual_skew_mode_b, .clock_delay_taps_a, .clock_delay_taps_b, .agg_width_sel, .rx_line_clock,
      .rx_line_data, .tx_status_in, .tx_status_clock, .tx_pll_clock, .fabric_tx_ref_clock, .loop_test_clock,
      .tx_serial_out, .rx_deserializer_out, .tx_data_path_out, .rx_status_path_out, .tx_parity,
      .rx_status_parity, .dyn_align_reset, .align_bypass, .static_capture_en(), .pll_bypass, .auto_center_en,
      .rx_clock_delay_taps, .status_io_standard_sel, .agg_width, .rx_serial_in, .serializer_in,
      .rx_data_path_in, .tx_status_path_in, .rx_status_out, .tx_parity_out, .rx_status_parity_out,
      .tx_data_clock_out(), .rx_status_clock_out(), .hs_block_clock_out());
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One bus access; the request stands until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [19:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= adr;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         num_errors++;
         print_verdict();
      end
   endtask : bus
   // Loop in force: far wins, then both near bits, then the serial bit alone.
   function automatic logic [1:0] exp_loop(input logic [7:0] v);
      if (v[1]) return 2'd2;
      if (v[5] && v[4]) return 2'd3;
      return v[4] ? 2'd1 : 2'd0;
   endfunction : exp_loop
   // Program one core, pulse its fabric reset, then compare the steered data, status and parity outputs; clock outputs are not checked.
   task run_cfg(input int c, input logic [7:0] v);
      logic [31:0] rd;
      logic [1:0] lp;
      logic q;
      lp = exp_loop(v);
      q = v[`SMLC_BIT_QUARTER];
      tx_data_path_out[c] <= $urandom;
      rx_deserializer_out[c] <= $urandom;
      tx_serial_out[c] <= LW'($urandom);
      rx_status_path_out[c] <= 2'($urandom);
      tx_parity[c] <= 4'($urandom);
      rx_status_parity[c] <= 2'($urandom);
      bus(1'b1, cadr[c], {24'($urandom), v}, rd);
      bus(1'b0, cadr[c], 32'h0000_0000, rd);
      check(rd, {24'h00_0000, v});
      fabric_core_reset[c] <= 1'b1;
      repeat (5) @(posedge clock);
      fabric_core_reset[c] <= 1'b0;
      repeat (4) @(posedge clock);
      bus(1'b0, sadr[c], 32'h0000_0000, rd);
      check(rd & 32'hFFFF_FFDF, {16'h0000, v, 3'h0, lp, q, 1'b1, q | ~v[2]});
      check({dyn_align_reset[c], align_bypass[c], pll_bypass[c], status_io_standard_sel[c]},
         {q | ~v[2], v[2] | q, q, v[3]});
      check(serializer_in[c], lp == 2'd2 ? rx_deserializer_out[c] : tx_data_path_out[c]);
      check(rx_data_path_in[c], lp == 2'd3 ? tx_data_path_out[c] : rx_deserializer_out[c]);
      check(tx_parity_out[c], tx_parity[c] ^ {4{v[6] & ~v[1]}});
      check(rx_status_parity_out[c], rx_status_parity[c] ^ {2{v[7] & ~v[1]}});
      if (lp == 2'd1 || lp == 2'd3) check(tx_status_path_in[c], rx_status_path_out[c]);
      if (lp == 2'd1) check(rx_serial_in[c], tx_serial_out[c]);
      if (lp != 2'd2) check(rx_status_out[c], rx_status_path_out[c]);
   endtask : run_cfg
   // Main sequence: reset values, mode table per core, unmapped access, skew and width.
   initial begin
      logic [31:0] rd;
      int c;
      int i;
      void'($urandom(32'h3ad6_b318));
      repeat (6) @(posedge clock);
      check({avs_waitrequest, dyn_align_reset, pll_bypass}, 5'b11100);
      check(avs_readdata, 32'h0000_0000);
      reset <= 1'b0;
      for (c = 0; c < 2; c++) begin
         for (i = 0; i < 20; i++) run_cfg(c, i < 14 ? CFGS[i] : 8'($urandom));
      end
      bus(1'b1, 20'h0_1000, $urandom, rd);
      bus(1'b0, 20'h0_1000, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      for (i = 0; i < 8; i++) begin
         manual_skew_mode_a <= (i == 0) | 1'($urandom);
         manual_skew_mode_b <= 1'($urandom);
         clock_delay_taps_a <= (i == 0) ? 3'h7 : 3'($urandom);
         clock_delay_taps_b <= 3'($urandom);
         agg_width_sel <= 4'($urandom);
         repeat (2) @(posedge clock);
         check({auto_center_en, rx_clock_delay_taps}, {~manual_skew_mode_b, ~manual_skew_mode_a,
            manual_skew_mode_b ? clock_delay_taps_b : 3'h0, manual_skew_mode_a ? clock_delay_taps_a : 3'h0});
         check(agg_width, agg_width_sel);
      end
      print_verdict();
   end
endmodule : tb_smlc_mode_ctrl
`default_nettype wire
